// ---- lio_ports.sv ----
module lio_ports
  import lio_pkg::*;
#(
  parameter int PM_ADDR_W = 12,
  parameter logic [PM_ADDR_W-6:0] TABLE_PAGE = '0
)
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // core commands
  input wire lio_cmd_s cmd,
  output logic busy_q,
  output logic rd_valid_q,
  output logic [3:0] rd_data_q,
  output logic test_bit_q,
  // program memory for table lookup
  output logic pm_req_q,
  output logic [PM_ADDR_W-1:0] pm_addr_q,
  input wire logic [7:0] pm_rdata,
  // output ports
  output logic [3:0] low_output_port_q,
  output logic [3:0] high_output_port_q,
  // scan ports, open drain, a through d from bit 0 up
  input wire logic [15:0] scan_pin_in,
  output logic [15:0] scan_pin_out_q,
  // shared event port, open drain
  input wire logic [3:0] shared_pin_in,
  output logic [3:0] shared_pin_out_q,
  // serial shared port
  input wire logic [2:0] serial_pin_in,
  output logic [2:0] serial_pin_out_q,
  input wire logic serial_enable,
  input wire logic [2:0] serial_drive,
  // external request events
  input wire logic irq_enable_bit_zero,
  output logic first_external_request_q,
  output logic second_external_request_q,
  output logic second_request_accept_q
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (PM_ADDR_W < LIO_TABLE_LOW_W + 1)
  begin : g_bad_width
    $error("lio_ports: PM_ADDR_W too small");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] low_q, low_d; // low output latch
  logic [3:0] high_q, high_d; // high output latch
  logic [15:0] scan_q, scan_d; // scan latches
  logic [3:0] shared_q, shared_d; // shared port latch
  logic [2:0] serial_q, serial_d; // serial port latch
  logic [1:0] sync1_q; // first sync stage, irq pins
  logic [1:0] sync2_q; // second sync stage
  logic [1:0] prev_q; // delayed level for edge detect

  // ----------------------------------------------------------------
  // set or clear one bit of a latch word
  // ----------------------------------------------------------------
  function automatic logic [3:0] bit_put(input logic [3:0] word,
                                         input logic [1:0] idx,
                                         input logic val);
    logic [3:0] res;
    res = word;
    res[idx] = val;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire take = ce & cmd.valid & ~busy_q; // command accepted this edge
  wire op_in = take & (cmd.op == LIO_OP_IN);
  wire op_out = take & (cmd.op == LIO_OP_OUT);
  wire op_set = take & (cmd.op == LIO_OP_SET);
  wire op_clr = take & (cmd.op == LIO_OP_CLR);
  wire op_test = take & (cmd.op == LIO_OP_TEST);
  wire op_table = take & (cmd.op == LIO_OP_TABLE);
  wire op_bit = op_set | op_clr; // single bit update
  wire hit_low = cmd.port == LIO_ADDR_LOW_OUT;
  wire hit_high = cmd.port == LIO_ADDR_HIGH_OUT;
  wire hit_scan = (cmd.port >= LIO_ADDR_SCAN_A) &
                  (cmd.port <= LIO_ADDR_SCAN_D);
  wire hit_shared = cmd.port == LIO_ADDR_SHARED;
  wire hit_serial = cmd.port == LIO_ADDR_SERIAL;
  wire [1:0] scan_sel = cmd.port[1:0]; // which scan nibble
  wire [1:0] bit_port = cmd.l_reg[3:2]; // scan port from L
  wire [1:0] bit_idx = cmd.l_reg[1:0]; // pin within port
  // table word lands when memory answers
  wire table_load = ce & pm_req_q;

  // ----------------------------------------------------------------
  // table lookup address
  // ----------------------------------------------------------------
  // address from carry and word
  wire [PM_ADDR_W-1:0] table_addr = {TABLE_PAGE, cmd.carry, cmd.hl_word};

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  wire [3:0] scan_nibble = scan_pin_in[{scan_sel, 2'b00} +: 4];
  wire [3:0] serial_read = {1'b1, serial_pin_in};
  wire [3:0] read_mux =
    hit_low ? low_q :
    hit_high ? high_q :
    hit_scan ? scan_nibble :
    hit_shared ? shared_pin_in :
    hit_serial ? serial_read :
    LIO_READ_UNMAPPED;
  wire test_pin = scan_pin_in[cmd.l_reg];

  // ----------------------------------------------------------------
  // output port latch next values
  // ----------------------------------------------------------------
  // table word to both ports
  assign low_d = table_load ? pm_rdata[3:0] :
                 (op_out & hit_low) ? cmd.wdata : low_q;
  assign high_d = table_load ? pm_rdata[7:4] :
                  (op_out & hit_high) ? cmd.wdata : high_q;

  // ----------------------------------------------------------------
  // scan latch next value
  // ----------------------------------------------------------------
  always_comb
  begin
    scan_d = scan_q;
    // whole nibble from out instruction
    if (op_out & hit_scan)
    begin
      scan_d[{scan_sel, 2'b00} +: 4] = cmd.wdata;
    end
    else if (op_bit)
    begin
      scan_d[{bit_port, 2'b00} +: 4] =
        bit_put(scan_q[{bit_port, 2'b00} +: 4], bit_idx, op_set);
    end
  end

  // ----------------------------------------------------------------
  // shared and serial latch next values
  // ----------------------------------------------------------------
  // shared port plain latch
  assign shared_d = (op_out & hit_shared) ? cmd.wdata : shared_q;
  assign serial_d = (op_out & hit_serial) ? cmd.wdata[2:0] : serial_q;

  // ----------------------------------------------------------------
  // latches
  // ----------------------------------------------------------------
  // combined address never decoded here
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_q <= LIO_RST_OUT_PORT;
      high_q <= LIO_RST_OUT_PORT;
      scan_q <= LIO_RST_SCAN;
      shared_q <= LIO_RST_SHARED;
      serial_q <= LIO_RST_SERIAL;
    end
    else if (ce)
    begin
      low_q <= low_d;
      high_q <= high_d;
      scan_q <= scan_d;
      shared_q <= shared_d;
      serial_q <= serial_d;
    end
  end

  // ----------------------------------------------------------------
  // table lookup sequencing
  // ----------------------------------------------------------------
  // no port operand used
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pm_req_q <= 1'b0;
      pm_addr_q <= '0;
      busy_q <= 1'b0;
    end
    else if (ce)
    begin
      pm_req_q <= op_table;
      busy_q <= op_table;
      // address held for the memory answer
      if (op_table)
      begin
        pm_addr_q <= table_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // read answers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      test_bit_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid_q <= op_in | op_test;
      // data only moves on a read
      if (op_in)
      begin
        rd_data_q <= read_mux;
      end
      if (op_test)
      begin
        test_bit_q <= test_pin;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // latch one releases pin; a serial pin also needs its serial_drive bit at one while serial_enable is set
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_output_port_q <= LIO_RST_OUT_PORT;
      high_output_port_q <= LIO_RST_OUT_PORT;
      scan_pin_out_q <= LIO_RST_SCAN;
      shared_pin_out_q <= LIO_RST_SHARED;
      serial_pin_out_q <= LIO_RST_SERIAL;
    end
    else if (ce)
    begin
      low_output_port_q <= low_d;
      high_output_port_q <= high_d;
      scan_pin_out_q <= scan_d;
      shared_pin_out_q <= shared_d;
      serial_pin_out_q <= serial_d &
                          (serial_enable ? serial_drive : 3'h7);
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin synchroniser and edge detect
  // ----------------------------------------------------------------
  // two-stage sync on pin levels
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= LIO_RST_SYNC;
      sync2_q <= LIO_RST_SYNC;
      prev_q <= LIO_RST_SYNC;
    end
    else if (ce)
    begin
      sync1_q <= {shared_pin_in[LIO_FIRST_IRQ_BIT],
                  shared_pin_in[LIO_SECOND_IRQ_BIT]};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  wire [1:0] fall = prev_q & ~sync2_q;

  // ----------------------------------------------------------------
  // request pulses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      first_external_request_q <= 1'b0;
      second_external_request_q <= 1'b0;
      second_request_accept_q <= 1'b0;
    end
    else if (ce)
    begin
      first_external_request_q <= fall[1];
      second_external_request_q <= fall[0];
      second_request_accept_q <= fall[0] & irq_enable_bit_zero;
    end
  end

endmodule // lio_ports

// ---- lio_pkg.sv ----
package lio_pkg;

  // ----------------------------------------------------------------
  // port addresses seen by the core
  // ----------------------------------------------------------------
  localparam logic [4:0] LIO_ADDR_LOW_OUT = 5'h01; // low_output_port
  localparam logic [4:0] LIO_ADDR_HIGH_OUT = 5'h02; // high_output_port
  localparam logic [4:0] LIO_ADDR_SCAN_A = 5'h04; // scan_port_a
  localparam logic [4:0] LIO_ADDR_SCAN_D = 5'h07; // scan_port_d
  localparam logic [4:0] LIO_ADDR_SHARED = 5'h08; // shared_event_port
  localparam logic [4:0] LIO_ADDR_SERIAL = 5'h09; // serial_shared_port
  localparam logic [4:0] LIO_ADDR_COMBINED = 5'h11; // combined_output_address

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LIO_FIRST_IRQ_BIT = 2; // first_ext_irq_pin in shared port
  localparam int LIO_SECOND_IRQ_BIT = 0; // second_ext_irq_pin in shared port
  localparam int LIO_TABLE_LOW_W = 5; // carry plus data memory word

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] LIO_RST_OUT_PORT = 4'h0; // output-only latches
  localparam logic [15:0] LIO_RST_SCAN = 16'hFFFF; // released, input ready
  localparam logic [3:0] LIO_RST_SHARED = 4'hF; // released, input ready
  localparam logic [2:0] LIO_RST_SERIAL = 3'h7; // released, input ready
  localparam logic [1:0] LIO_RST_SYNC = 2'h3; // idle-high pin level
  localparam logic [3:0] LIO_READ_UNMAPPED = 4'h0; // unmapped read value

  // ----------------------------------------------------------------
  // latency
  // ----------------------------------------------------------------
  localparam int LIO_TABLE_CYCLES = 2; // table lookup span: command cycle plus one busy_q cycle

  // ----------------------------------------------------------------
  // core instruction codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LIO_OP_NONE,
    LIO_OP_IN,
    LIO_OP_OUT,
    LIO_OP_SET,
    LIO_OP_CLR,
    LIO_OP_TEST,
    LIO_OP_TABLE
  } lio_op_e;

  // core command carrier
  typedef struct packed {
    logic valid; // command strobe
    lio_op_e op; // instruction kind
    logic [4:0] port; // port address for in and out
    logic [3:0] wdata; // data for out
    logic [3:0] l_reg; // index for bit set, clear, test
    logic [3:0] hl_word; // data memory word at H and L
    logic carry; // carry flag
  } lio_cmd_s;

endpackage : lio_pkg

// ---- lio_ports_monitor.sv ----
// ------------------------------------
// port block checker
// ------------------------------------
module lio_ports_monitor
  import lio_pkg::*;
#(
  parameter int PM_ADDR_W = 12
)
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // core side
  input wire lio_cmd_s cmd,
  input wire logic busy_q,
  input wire logic rd_valid_q,
  input wire logic [3:0] rd_data_q,
  input wire logic pm_req_q,
  input wire logic [PM_ADDR_W-1:0] pm_addr_q,
  input wire logic [7:0] pm_rdata,
  // ports
  input wire logic [3:0] low_output_port_q,
  input wire logic [3:0] high_output_port_q,
  input wire logic [15:0] scan_pin_out_q,
  input wire logic [3:0] shared_pin_in,
  input wire logic irq_enable_bit_zero,
  input wire logic first_external_request_q,
  input wire logic second_external_request_q,
  input wire logic second_request_accept_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, quiet in reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // accepted commands by kind, as the block takes them
  wire logic take = ce && cmd.valid && !busy_q;
  wire logic t_tab = take && cmd.op == LIO_OP_TABLE;
  wire logic t_set = take && cmd.op == LIO_OP_SET;
  wire logic t_clr = take && cmd.op == LIO_OP_CLR;
  wire logic t_out = take && cmd.op == LIO_OP_OUT;
  wire logic t_in = take && cmd.op == LIO_OP_IN;
  a_table_fetch: assert property (t_tab |=>
    pm_req_q && busy_q &&
    pm_addr_q[4:0] == {$past(cmd.carry), $past(cmd.hl_word)})
    else $error("table fetch wrong");
  a_table_load: assert property (pm_req_q |=>
    {high_output_port_q, low_output_port_q} == $past(pm_rdata))
    else $error("table word not loaded");
  a_busy_single: assert property (busy_q |=> !busy_q)
    else $error("busy too long");
  a_set_latch: assert property (t_set |=> scan_pin_out_q ==
    ($past(scan_pin_out_q) | (16'h0001 << $past(cmd.l_reg))))
    else $error("bit set wrong");
  a_clr_latch: assert property (t_clr |=> scan_pin_out_q ==
    ($past(scan_pin_out_q) & ~(16'h0001 << $past(cmd.l_reg))))
    else $error("bit clear wrong");
  a_combined_ignored: assert property (t_out
    && cmd.port == LIO_ADDR_COMBINED |=>
    $stable({high_output_port_q, low_output_port_q}))
    else $error("combined address written");
  a_serial_top: assert property (t_in
    && cmd.port == LIO_ADDR_SERIAL |=> rd_valid_q && rd_data_q[3])
    else $error("absent serial bit not one");
  a_first_edge: assert property ($fell(shared_pin_in[2])
    |-> ##[3:4] first_external_request_q)
    else $error("first request missing");
  a_first_pulse: assert property (first_external_request_q
    |=> !first_external_request_q)
    else $error("first request too long");
  a_second_gate: assert property (second_request_accept_q
    |-> $past(irq_enable_bit_zero))
    else $error("second request accepted while gated");
  a_accept_match: assert property (second_request_accept_q ==
    (second_external_request_q && $past(irq_enable_bit_zero)))
    else $error("second accept not matching request");
  // main scenarios reached
  c_table: cover property (t_tab);
  c_set: cover property (t_set);
  c_first: cover property (first_external_request_q);
  c_accept: cover property (second_request_accept_q);
endmodule // lio_ports_monitor

bind lio_ports lio_ports_monitor #(.PM_ADDR_W(PM_ADDR_W)) mon_u (
  .sys_clk, .resetn, .ce, .cmd, .busy_q, .rd_valid_q, .rd_data_q, .pm_req_q,
  .pm_addr_q, .pm_rdata, .low_output_port_q, .high_output_port_q,
  .scan_pin_out_q, .shared_pin_in, .irq_enable_bit_zero,
  .first_external_request_q, .second_external_request_q,
  .second_request_accept_q);

// ---- lio_pin_model.sv ----
// ------------------------------------
// outside circuits on the pins
// ------------------------------------
module lio_pin_model
(
  // latch outputs of the block
  input wire logic [15:0] scan_out,
  input wire logic [3:0] shared_out,
  input wire logic [2:0] serial_out,
  // lines pulled low from outside
  input wire logic [15:0] scan_low,
  input wire logic [3:0] shared_low,
  input wire logic [2:0] serial_low,
  // resolved levels, pull-up when released
  output logic [15:0] scan_pin,
  output logic [3:0] shared_pin,
  output logic [2:0] serial_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign scan_pin = scan_out & ~scan_low;
  assign shared_pin = shared_out & ~shared_low;
  assign serial_pin = serial_out & ~serial_low;
endmodule // lio_pin_model

// ---- testbench.sv ----
module testbench
  import lio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------
  // stimulus and observed signals
  // ------------------------------------
  logic sys_clk = 0, resetn = 0, ce = 1'b1, serial_enable = 0;
  logic irq_enable_bit_zero = 0;
  logic [2:0] serial_drive = 3'h7;
  lio_cmd_s cmd = '0;
  logic [15:0] scan_low = '0;
  logic [3:0] sh_low = '0;
  logic [15:0] tab_exp = '0; // expected table word on the ports
  wire logic busy_q, rd_valid_q, test_bit_q, pm_req_q;
  wire logic [3:0] rd_data_q, low_output_port_q, high_output_port_q;
  wire logic [11:0] pm_addr_q;
  wire logic [7:0] pm_rdata;
  wire logic [15:0] scan_pin_in, scan_pin_out_q;
  wire logic [3:0] shared_pin_in, shared_pin_out_q;
  wire logic [2:0] serial_pin_in, serial_pin_out_q;
  wire logic first_external_request_q, second_external_request_q;
  wire logic second_request_accept_q;
  int error_cnt = 0, num_checks = 0, n1 = 0, n2 = 0, na = 0, cyc = 0;
  // one row: write port, data, read port, expected
  typedef struct packed {
    logic [4:0] wp; logic [3:0] wd; logic [4:0] rp; logic [3:0] ex;
  } lio_row_s;
  lio_row_s rows [5] = '{'{5'h01, 4'h5, 5'h01, 4'h5},
    '{5'h02, 4'hA, 5'h02, 4'hA}, '{5'h04, 4'h3, 5'h04, 4'h3},
    '{5'h09, 4'h2, 5'h09, 4'hA}, '{5'h11, 4'h0, 5'h01, 4'h5}};
  // table memory, inverted word when not read
  function automatic logic [7:0] pm_word(input logic [4:0] a);
    return {3'h5, a} ^ 8'h96;
  endfunction
  assign pm_rdata = pm_req_q ? pm_word(pm_addr_q[4:0])
                             : ~pm_word(pm_addr_q[4:0]);
  lio_ports dut_u (.sys_clk, .resetn, .ce, .cmd, .busy_q, .rd_valid_q,
    .rd_data_q, .test_bit_q, .pm_req_q, .pm_addr_q, .pm_rdata,
    .low_output_port_q, .high_output_port_q, .scan_pin_in, .scan_pin_out_q,
    .shared_pin_in, .shared_pin_out_q, .serial_pin_in, .serial_pin_out_q,
    .serial_enable, .serial_drive, .irq_enable_bit_zero,
    .first_external_request_q, .second_external_request_q,
    .second_request_accept_q);
  lio_pin_model pins_u (.scan_out(scan_pin_out_q),
    .shared_out(shared_pin_out_q), .serial_out(serial_pin_out_q),
    .scan_low(scan_low), .shared_low(sh_low), .serial_low(3'h0),
    .scan_pin(scan_pin_in), .shared_pin(shared_pin_in),
    .serial_pin(serial_pin_in));
  always #5 sys_clk = ~sys_clk;
  // pulse counters and hang limit
  always @(posedge sys_clk)
  begin
    cyc++;
    if (first_external_request_q === 1'b1) n1++;
    if (second_external_request_q === 1'b1) n2++;
    if (second_request_accept_q === 1'b1) na++;
    // far above the roughly 125 cycles of the run
    if (cyc == 2000)
    begin
      error_cnt++;
      final_report();
    end
  end
  // ------------------------------------
  // tasks
  // ------------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_cnt(input int g, input int e);
    num_checks++;
    if (g != e)
    begin
      error_cnt++;
      $display("MISMATCH %0t count %0d exp %0d", $time, g, e);
    end
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // strobe stays up; idle lowers it
  task issue(input lio_op_e op, input logic [4:0] p, input logic [3:0] d,
             input logic [3:0] l);
    cmd = '{valid: 1'b1, op: op, port: p, wdata: d, l_reg: l,
            hl_word: d, carry: l[0]};
    wait_cyc(1);
  endtask
  task idle;
    cmd.valid = 1'b0;
    wait_cyc(1);
  endtask
  task final_report;
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    wait_cyc(16);
    resetn = 1;
    // reset values of the pin latches
    chk(scan_pin_out_q, 16'hFFFF);
    chk(16'({shared_pin_out_q, serial_pin_out_q}), 16'h007F);
    // every L value: clear, set, then test the pin
    scan_low = 16'h0101;
    for (int i = 0; i < 16; i++)
    begin
      issue(LIO_OP_CLR, 5'h00, 4'h0, i[3:0]);
      chk(scan_pin_out_q, ~(16'h0001 << i));
      issue(LIO_OP_SET, 5'h00, 4'h0, i[3:0]);
      chk(scan_pin_out_q, 16'hFFFF);
      issue(LIO_OP_TEST, 5'h00, 4'h0, i[3:0]);
      chk(16'(test_bit_q), 16'(!scan_low[i]));
    end
    scan_low = '0;
    // rows: write a port, then read the row's read port
    foreach (rows[k])
    begin
      issue(LIO_OP_OUT, rows[k].wp, rows[k].wd, 4'h0);
      issue(LIO_OP_IN, rows[k].rp, 4'h0, 4'h0);
      chk(16'({rd_valid_q, rd_data_q}), {12'h001, rows[k].ex});
    end
    // table lookup, then a port write refused while busy
    issue(LIO_OP_TABLE, 5'h00, 4'h6, 4'h1);
    chk(16'({pm_req_q, busy_q, pm_addr_q}), 16'h3016);
    tab_exp = 16'(pm_word(5'h16));
    issue(LIO_OP_OUT, LIO_ADDR_SCAN_A, 4'h9, 4'h0);
    chk(16'({high_output_port_q, low_output_port_q}), tab_exp);
    chk(scan_pin_out_q, 16'hFFF3);
    // serial gate while enabled, plain latch once disabled
    serial_enable = 1'b1;
    serial_drive = 3'h5;
    issue(LIO_OP_OUT, LIO_ADDR_SERIAL, 4'h6, 4'h0);
    chk(16'(serial_pin_out_q), 16'h0004);
    serial_enable = 1'b0;
    issue(LIO_OP_OUT, LIO_ADDR_SERIAL, 4'h6, 4'h0);
    chk(16'(serial_pin_out_q), 16'h0006);
    issue(LIO_OP_IN, LIO_ADDR_SERIAL, 4'h0, 4'h0);
    chk(16'(rd_data_q), 16'h000E);
    // own output pulls the first request pin low
    issue(LIO_OP_OUT, LIO_ADDR_SHARED, 4'hB, 4'h0);
    issue(LIO_OP_IN, LIO_ADDR_SHARED, 4'h0, 4'h0);
    chk(16'(rd_data_q), 16'h000B);
    idle;
    wait_cyc(6);
    chk_cnt(n1, 1);
    issue(LIO_OP_OUT, LIO_ADDR_SHARED, 4'hF, 4'h0);
    idle;
    // second pin pulled low, gate shut then open
    for (int e = 0; e < 2; e++)
    begin
      irq_enable_bit_zero = e[0];
      sh_low = 4'h1;
      wait_cyc(6);
      sh_low = 4'h0;
      wait_cyc(6);
    end
    chk_cnt(n1, 1);
    chk_cnt(n2, 2);
    chk_cnt(na, 1);
    // clock enable low freezes the latches
    ce = 1'b0;
    issue(LIO_OP_OUT, LIO_ADDR_LOW_OUT, 4'h9, 4'h0);
    chk(16'({high_output_port_q, low_output_port_q}), tab_exp);
    idle;
    ce = 1'b1;
    // mid-run reset with the first request pin held low
    resetn = 1'b0;
    sh_low = 4'h4;
    #1;
    chk(16'({low_output_port_q, high_output_port_q}), 16'h0000);
    chk(16'({shared_pin_out_q, serial_pin_out_q}), 16'h007F);
    chk(scan_pin_out_q, 16'hFFFF);
    wait_cyc(2);
    resetn = 1'b1;
    issue(LIO_OP_IN, LIO_ADDR_LOW_OUT, 4'h0, 4'h0);
    chk(16'({rd_valid_q, rd_data_q}), 16'h0010);
    idle;
    wait_cyc(4);
    chk_cnt(n1, 2);
    sh_low = 4'h0;
    final_report();
  end
endmodule // testbench
